// ### hdl/ups_consts.svh
`ifndef UPS_CONSTS_SVH
`define UPS_CONSTS_SVH

// command word bits
`define UPS_CMD_TXEN   3'd0
`define UPS_CMD_DTR    3'd1
`define UPS_CMD_RXEN   3'd2
`define UPS_CMD_BREAK  3'd3
`define UPS_CMD_ERRCLR 3'd4
`define UPS_CMD_RTS    3'd5
`define UPS_CMD_SOFT   3'd6
`define UPS_CMD_HUNT   3'd7
`define UPS_CMD_RESET  8'h00

// mode word fields
`define UPS_MODE_PEN   3'd4
`define UPS_MODE_EP    3'd5
`define UPS_MODE_SCS   3'd7
`define UPS_MODE_STOP2 3'd7
`define UPS_MODE_SYNC  2'h0
`define UPS_MODE_RESET 8'h00
`define UPS_SYNC_RESET 8'h00
`define UPS_LEN_BASE   4'h5

// link frame sizes
`define UPS_FRAME_W    12
`define UPS_FRAME_CW   4

`endif

// ### hdl/ups_pkg.sv
package ups_pkg;
	typedef enum logic [3:0] {
		UPS_ST_MODE  = 4'b0001,
		UPS_ST_SYNC1 = 4'b0010,
		UPS_ST_SYNC2 = 4'b0100,
		UPS_ST_RUN   = 4'b1000
	} ups_state_e;

	typedef struct packed {
		logic       stop_bad;
		logic       parity_bad;
		logic [7:0] data;
	} ups_rx_word_s;

	typedef struct packed {
		logic dsr;
		logic syn_brk;
		logic framing_fault;
		logic overrun;
		logic parity_fault;
		logic tx_empty;
		logic rx_ready;
		logic tx_ready;
	} ups_status_s;

	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic       cnd;
		logic [7:0] din;
	} ups_host_s;
endpackage : ups_pkg

// ### hdl/ups_port.sv
`timescale 1ns/1ns
`include "ups_consts.svh"
module ups_port (
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire logic               link_clk,
	input  wire logic               cs_n,
	input  wire logic               rd_n,
	input  wire logic               wr_n,
	input  wire logic               cnd,
	input  wire logic [7:0]         din,
	input  wire logic               cts_n,
	input  wire logic               dsr_n,
	input  wire logic               syn_brk_in,
	input  wire logic               rx_word_strobe,
	input  wire ups_pkg::ups_rx_word_s rx_word,
	output logic      [7:0]         dout,
	output logic                    dtr_n,
	output logic                    rts_n,
	output logic                    tx_enable,
	output logic                    rx_enable,
	output logic                    sync_hunt_start,
	output logic                    txrdy,
	output logic                    rxrdy,
	output logic                    txempty,
	output logic                    syn_brk,
	output logic      [7:0]         sync_char_first,
	output logic      [7:0]         sync_char_second,
	output logic                    txd
);
	ups_pkg::ups_host_s   hs1, hs2;
	logic                 wr_d, rd_d;
	logic [2:0]           misc1, misc2;
	ups_pkg::ups_state_e  st;
	logic [7:0]           mode_word_reg, command_word;
	logic [7:0]           tx_holding_reg, rx_holding_reg;
	logic                 hold_full, req_tgl, req_out;
	logic                 parity_fault, overrun, framing_fault;
	logic [2:0]           ack_s;
	logic [1:0]           busy_s;
	logic [2:0]           rxt_s;
	ups_pkg::ups_status_s status;
	logic                 wr_evt, rd_evt, wr_ctl, wr_cmd, wr_dat, rd_dat;
	logic                 sync_mode, ack_evt, rx_evt, err_clr;
	logic [7:0]           next_dout;
	// link side state, declared up front: the clk side reads it
	logic [2:0]           lk_req_s;
	logic                 lk_ack, lk_busy, lk_pend, lk_rx_tgl;
	logic [1:0]           lk_brk_s;
	logic [`UPS_FRAME_W-1:0]  lk_frame, next_frame;
	logic [`UPS_FRAME_CW-1:0] lk_cnt, next_cnt;
	ups_pkg::ups_rx_word_s lk_rx;

	// host pins are asynchronous to clk: two flops before use
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hs1 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, cnd: 1'b0,
				din: 8'h00};
			hs2 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, cnd: 1'b0,
				din: 8'h00};
			wr_d <= 1'b1;
			rd_d <= 1'b1;
		end else begin
			hs1 <= '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, cnd: cnd,
				din: din};
			hs2 <= hs1;
			wr_d <= hs2.wr_n;
			rd_d <= hs2.rd_n;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			misc1 <= 3'h7;
			misc2 <= 3'h7;
		end else begin
			misc1 <= {cts_n, dsr_n, syn_brk_in};
			misc2 <= misc1;
		end
	end

	// strobes act on their trailing edge, when data has settled
	assign wr_evt = hs2.wr_n && !wr_d && !hs2.cs_n;
	assign rd_evt = hs2.rd_n && !rd_d && !hs2.cs_n;
	assign wr_ctl = wr_evt && hs2.cnd;
	assign wr_cmd = wr_ctl && (st == ups_pkg::UPS_ST_RUN);
	assign wr_dat = wr_evt && !hs2.cnd && (st == ups_pkg::UPS_ST_RUN);
	assign rd_dat = rd_evt && !hs2.cnd;
	assign sync_mode = (mode_word_reg[1:0] == `UPS_MODE_SYNC);
	assign err_clr = wr_cmd && hs2.din[`UPS_CMD_ERRCLR];

	// programming sequence
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= ups_pkg::UPS_ST_MODE;
		end else if (wr_ctl) begin
			case (st)
				ups_pkg::UPS_ST_MODE: begin
					if (hs2.din[1:0] == `UPS_MODE_SYNC)
						st <= ups_pkg::UPS_ST_SYNC1;
					else
						st <= ups_pkg::UPS_ST_RUN;
				end
				ups_pkg::UPS_ST_SYNC1: begin
					if (mode_word_reg[`UPS_MODE_SCS])
						st <= ups_pkg::UPS_ST_RUN;
					else
						st <= ups_pkg::UPS_ST_SYNC2;
				end
				ups_pkg::UPS_ST_SYNC2: st <= ups_pkg::UPS_ST_RUN;
				ups_pkg::UPS_ST_RUN: begin
					if (hs2.din[`UPS_CMD_SOFT])
						st <= ups_pkg::UPS_ST_MODE;
				end
				default: st <= ups_pkg::UPS_ST_MODE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_word_reg    <= `UPS_MODE_RESET;
			sync_char_first  <= `UPS_SYNC_RESET;
			sync_char_second <= `UPS_SYNC_RESET;
		end else if (wr_ctl) begin
			if (st == ups_pkg::UPS_ST_MODE)
				mode_word_reg <= hs2.din;
			if (st == ups_pkg::UPS_ST_SYNC1)
				sync_char_first <= hs2.din;
			if (st == ups_pkg::UPS_ST_SYNC2)
				sync_char_second <= hs2.din;
		end
	end

	// soft reset clears the command word: DTR, RTS and both enables idle until reprogrammed
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			command_word <= `UPS_CMD_RESET;
		else if (wr_cmd && hs2.din[`UPS_CMD_SOFT])
			command_word <= `UPS_CMD_RESET;
		else if (wr_cmd)
			command_word <= hs2.din;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dtr_n           <= 1'b1;
			rts_n           <= 1'b1;
			tx_enable       <= 1'b0;
			rx_enable       <= 1'b0;
			sync_hunt_start <= 1'b0;
		end else begin
			dtr_n     <= !command_word[`UPS_CMD_DTR];
			rts_n     <= !command_word[`UPS_CMD_RTS];
			tx_enable <= command_word[`UPS_CMD_TXEN];
			rx_enable <= command_word[`UPS_CMD_RXEN];
			sync_hunt_start <= wr_cmd && sync_mode &&
				hs2.din[`UPS_CMD_HUNT] && !hs2.din[`UPS_CMD_SOFT];
		end
	end

	// transmit holding register and hand-over to the link side
	assign ack_evt = ack_s[2] ^ ack_s[1];
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_holding_reg <= 8'h00;
			hold_full      <= 1'b0;
			req_tgl        <= 1'b0;
			req_out        <= 1'b0;
		end else begin
			if (wr_dat && !req_out)
				tx_holding_reg <= hs2.din;
			if (wr_dat)
				hold_full <= 1'b1;
			else if (ack_evt)
				hold_full <= 1'b0;
			// data must stay still while the link may copy it
			if (ack_evt) begin
				req_out <= 1'b0;
			end else if (hold_full && !req_out && tx_enable) begin
				req_tgl <= !req_tgl;
				req_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_s  <= 3'h0;
			busy_s <= 2'h0;
			rxt_s  <= 3'h0;
		end else begin
			ack_s  <= {ack_s[1:0], lk_ack};
			busy_s <= {busy_s[0], lk_busy};
			rxt_s  <= {rxt_s[1:0], lk_rx_tgl};
		end
	end

	// received words and fault flags; a set wins over any clear
	assign rx_evt = rxt_s[2] ^ rxt_s[1];
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_holding_reg <= 8'h00;
			rxrdy          <= 1'b0;
		end else begin
			if (rx_evt && !rxrdy)
				rx_holding_reg <= lk_rx.data;
			if (rx_evt)
				rxrdy <= 1'b1;
			else if (rd_dat || (wr_cmd && hs2.din[`UPS_CMD_SOFT]))
				rxrdy <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			parity_fault  <= 1'b0;
			overrun       <= 1'b0;
			framing_fault <= 1'b0;
		end else begin
			if (rx_evt && lk_rx.parity_bad && mode_word_reg[`UPS_MODE_PEN])
				parity_fault <= 1'b1;
			else if (err_clr || (wr_cmd && hs2.din[`UPS_CMD_SOFT]))
				parity_fault <= 1'b0;
			if (rx_evt && rxrdy)
				overrun <= 1'b1;
			else if (err_clr || (wr_cmd && hs2.din[`UPS_CMD_SOFT]))
				overrun <= 1'b0;
			if (rx_evt && lk_rx.stop_bad && !sync_mode)
				framing_fault <= 1'b1;
			else if (err_clr || (wr_cmd && hs2.din[`UPS_CMD_SOFT]))
				framing_fault <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			txrdy   <= 1'b0;
			txempty <= 1'b1;
			syn_brk <= 1'b0;
		end else begin
			txrdy   <= !hold_full && !misc2[2] && tx_enable;
			txempty <= !hold_full && !req_out && !busy_s[1];
			syn_brk <= misc2[0];
		end
	end

	always_comb begin
		status.tx_ready      = !hold_full;
		status.rx_ready      = rxrdy;
		status.tx_empty      = txempty;
		status.parity_fault  = parity_fault;
		status.overrun       = overrun;
		status.framing_fault = framing_fault;
		status.syn_brk       = syn_brk;
		status.dsr           = !misc2[1];
		next_dout = hs2.cnd ? status : rx_holding_reg;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			dout <= 8'h00;
		else if (!hs2.rd_n && !hs2.cs_n)
			dout <= next_dout;
	end

	// link domain: transmit shifter on the serial clock

	always_comb begin
		logic [3:0] len;
		logic [3:0] pos;
		logic [7:0] dm;
		len = `UPS_LEN_BASE + {2'h0, mode_word_reg[3:2]};
		pos = 4'h0;
		dm  = 8'h00;
		next_frame = '1;
		if (!sync_mode) begin
			next_frame[0] = 1'b0;
			pos = 4'h1;
		end
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < len) begin
				dm[i] = tx_holding_reg[i];
				next_frame[pos + 4'(i)] = tx_holding_reg[i];
			end
		end
		pos = pos + len;
		if (mode_word_reg[`UPS_MODE_PEN]) begin
			next_frame[pos] = mode_word_reg[`UPS_MODE_EP] ? ^dm : ~^dm;
			pos = pos + 4'h1;
		end
		if (!sync_mode)
			pos = pos + (mode_word_reg[`UPS_MODE_STOP2] ? 4'h2 : 4'h1);
		next_cnt = pos;
	end

	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			lk_req_s <= 3'h0;
			lk_brk_s <= 2'h0;
		end else begin
			lk_req_s <= {lk_req_s[1:0], req_tgl};
			lk_brk_s <= {lk_brk_s[0], command_word[`UPS_CMD_BREAK]};
		end
	end

	// holding data is static while a request is pending
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			lk_pend  <= 1'b0;
			lk_ack   <= 1'b0;
			lk_busy  <= 1'b0;
			lk_frame <= '1;
			lk_cnt   <= '0;
		end else begin
			if (lk_req_s[2] ^ lk_req_s[1])
				lk_pend <= 1'b1;
			if (lk_busy) begin
				lk_frame <= {1'b1, lk_frame[`UPS_FRAME_W-1:1]};
				lk_cnt   <= lk_cnt - 4'h1;
				if (lk_cnt == 4'h1)
					lk_busy <= 1'b0;
			end else if (lk_pend) begin
				lk_frame <= next_frame;
				lk_cnt   <= next_cnt;
				lk_busy  <= 1'b1;
				lk_pend  <= 1'b0;
				lk_ack   <= !lk_ack;
			end
		end
	end

	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n)
			txd <= 1'b1;
		else
			txd <= lk_brk_s[1] ? 1'b0 : (!lk_busy || lk_frame[0]);
	end

	// receive word capture, handed over by toggle
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			lk_rx     <= '0;
			lk_rx_tgl <= 1'b0;
		end else if (rx_word_strobe) begin
			lk_rx     <= rx_word;
			lk_rx_tgl <= !lk_rx_tgl;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_dtr_level: assert property (dtr_n == !$past(command_word[1]))
		else $error("terminal-ready wrong");
	a_rts_level: assert property (rts_n == !$past(command_word[5]))
		else $error("send-request wrong");
	a_err_clear: assert property (err_clr && !rx_evt |=>
		!parity_fault && !overrun && !framing_fault)
		else $error("error flags not cleared");
	a_soft_reset: assert property (wr_cmd && hs2.din[6] |=>
		st == ups_pkg::UPS_ST_MODE && command_word == 8'h00)
		else $error("soft reset missed");
	a_mode_first: assert property (wr_ctl && st == ups_pkg::UPS_ST_MODE
		|=> mode_word_reg == $past(hs2.din))
		else $error("mode word not stored");
	a_async_skip: assert property (wr_ctl &&
		st == ups_pkg::UPS_ST_MODE && hs2.din[1:0] != 2'h0
		|=> st == ups_pkg::UPS_ST_RUN)
		else $error("async did not skip sync");
	a_sync_order: assert property (wr_ctl &&
		st == ups_pkg::UPS_ST_SYNC1 |=> sync_char_first == $past(hs2.din)
		&& st == (mode_word_reg[7] ? ups_pkg::UPS_ST_RUN
		: ups_pkg::UPS_ST_SYNC2))
		else $error("sync character order wrong");
	a_overrun_set: assert property (rx_evt && rxrdy |=> overrun
		&& $stable(rx_holding_reg))
		else $error("overrun missed");
	a_cs_ignore: assert property (hs2.cs_n |=> $stable(st)
		&& $stable(command_word) && $stable(mode_word_reg))
		else $error("access taken with cs high");
	a_hunt_async: assert property (sync_hunt_start |-> sync_mode)
		else $error("hunt in async mode");
	a_parity_off: assert property (!mode_word_reg[4] && !parity_fault
		|=> !parity_fault)
		else $error("parity fault without parity");
	a_tx_load: assert property (@(posedge link_clk) disable iff (!arst_n)
		lk_busy && lk_cnt > 4'h1 |=> lk_busy)
		else $error("shifter reloaded early");

	c_async_setup: cover property (wr_ctl && st == ups_pkg::UPS_ST_MODE
		##[1:1000] st == ups_pkg::UPS_ST_RUN);
	c_two_sync: cover property (st == ups_pkg::UPS_ST_SYNC2 ##1
		st == ups_pkg::UPS_ST_RUN);
	c_overrun: cover property (rx_evt && rxrdy);
	c_tx_done: cover property (ack_evt ##[1:1000] txempty);
endmodule : ups_port

// ### tb/ups_host_model.sv
`timescale 1ns/1ns
module ups_host_model (
	input  wire logic       clk,
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic            cnd,
	output logic      [7:0] din,
	input  wire logic [7:0] dout
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		cnd  = 1'b1;
		din  = 8'h00;
	end

	// strobe low 6 clk, select and data kept 4 clk past the rising strobe
	// so the synced sample still sees them at the taking edge
	task automatic access(input logic sel_n, input logic c, input logic rd,
			input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		cs_n = sel_n;
		cnd  = c;
		din  = d;
		rd_n = ~rd;
		wr_n = rd;
		repeat (6) @(negedge clk);
		q    = dout;
		rd_n = 1'b1;
		wr_n = 1'b1;
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		// released bus shows no stale value
		din  = ~din;
		cnd  = ~cnd;
		repeat (4) @(negedge clk);
	endtask : access
endmodule : ups_host_model

// ### tb/test_usart_host_register_port.sv
`timescale 1ns/1ns
module test_usart_host_register_port;
	logic                  clk, arst_n, link_clk, cs_n, rd_n, wr_n, cnd;
	logic                  cts_n, dsr_n, syn_brk_in, rx_word_strobe;
	logic                  dtr_n, rts_n, tx_enable, rx_enable, hunt, txrdy;
	logic                  rxrdy, txempty, syn_brk, txd;
	logic [7:0]            din, dout, sc1, sc2, q, c, s1, s2, d1;
	ups_pkg::ups_rx_word_s rx_word;
	logic [31:0]           seed;
	logic [3:0]            mon_cnt;
	logic [8:0]            mon_sh;
	logic [8:0]            mon_q[$];
	int                    fails, total_checks, hunt_cnt, n;

	ups_host_model u_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.cnd(cnd), .din(din), .dout(dout));
	ups_port dut (.clk(clk), .arst_n(arst_n), .link_clk(link_clk),
		.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .cnd(cnd), .din(din),
		.cts_n(cts_n), .dsr_n(dsr_n), .syn_brk_in(syn_brk_in),
		.rx_word_strobe(rx_word_strobe), .rx_word(rx_word), .dout(dout),
		.dtr_n(dtr_n), .rts_n(rts_n), .tx_enable(tx_enable),
		.rx_enable(rx_enable), .sync_hunt_start(hunt), .txrdy(txrdy),
		.rxrdy(rxrdy), .txempty(txempty), .syn_brk(syn_brk),
		.sync_char_first(sc1), .sync_char_second(sc2), .txd(txd));

	always #2 clk = ~clk;
	// odd offset keeps link edges off the main clock edges
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	always @(negedge clk) if (hunt === 1'b1) hunt_cnt++;
	// serial frame capture: 8 data bits lsb first, then parity
	always @(negedge link_clk) begin
		if (mon_cnt == 4'h0) begin
			if (txd === 1'b0)
				mon_cnt <= 4'h1;
		end else if (mon_cnt == 4'ha) begin
			mon_q.push_back(mon_sh);
			mon_cnt <= 4'h0;
		end else begin
			mon_sh  <= {txd, mon_sh[8:1]};
			mon_cnt <= mon_cnt + 4'h1;
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] outs(input logic [7:0] w);
		return {4'h0, ~w[5], w[2], ~w[1], w[0]};
	endfunction : outs
	function automatic logic [7:0] stat(input logic h, input logic rr,
			input logic te, input logic pe, input logic oe, input logic fe);
		return {~dsr_n, syn_brk_in, fe, oe, pe, te, rr, h};
	endfunction : stat

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic cd, input logic [7:0] d);
		logic [7:0] r;
		u_host.access(1'b0, cd, 1'b0, d, r);
	endtask : wr
	task automatic rd(input logic cd, output logic [7:0] r);
		u_host.access(1'b0, cd, 1'b1, 8'h00, r);
	endtask : rd
	task automatic send_rx(input logic sb, input logic pb, input logic [7:0] d);
		@(negedge link_clk);
		rx_word_strobe = 1'b1;
		rx_word        = {sb, pb, d};
		@(negedge link_clk);
		rx_word_strobe = 1'b0;
		rx_word        = ~rx_word;
		repeat (10) @(negedge clk);
	endtask : send_rx

	initial begin
		clk            = 1'b0;
		arst_n         = 1'b0;
		cts_n          = 1'b1;
		dsr_n          = 1'b0;
		syn_brk_in     = 1'b0;
		rx_word_strobe = 1'b0;
		rx_word = '0;
		seed = 32'h0001180f;
		fails        = 0;
		total_checks = 0;
		hunt_cnt     = 0;
		mon_cnt = 4'h0;
		mon_sh = '0;
		// two link edges inside reset as well, for the link side flops
		repeat (4) @(negedge clk);
		repeat (2) @(posedge link_clk);
		@(negedge clk);
		arst_n = 1'b1;
		check({dtr_n, rts_n, tx_enable, rx_enable,
			txempty, txd, rxrdy, 1'b0}, 8'hcc);
		check(sc1 | sc2, 8'h00);
		$display("test reset done");
		seed = lfsr(lfsr(seed));
		s1 = seed[7:0];
		s2 = seed[15:8];
		wr(1'b1, 8'h00);
		wr(1'b1, s1);
		wr(1'b1, s2);
		check(sc1, s1);
		check(sc2, s2);
		$display("test sync setup done");
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			c = (i == 0) ? 8'h88 : seed[7:0] & 8'hbf;
			n = hunt_cnt;
			wr(1'b1, c);
			// break crosses three link flops: wait out four link periods
			repeat (50) @(negedge clk);
			check({rts_n, rx_enable, dtr_n, tx_enable},
				outs(c));
			check({7'h0, txd}, {7'h0, ~c[3]});
			check(8'(hunt_cnt - n), {7'h0, c[7]});
		end
		$display("test command bits done");
		seed = lfsr(seed);
		dsr_n = seed[0];
		syn_brk_in = 1'b1;
		wr(1'b1, 8'h04);
		rd(1'b1, q);
		check(q, stat(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
		check({7'h0, txrdy}, 8'h00);
		check({7'h0, syn_brk}, 8'h01);
		d1 = seed[15:8];
		send_rx(1'b1, 1'b1, d1);
		rd(1'b1, q);
		check(q, stat(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
		send_rx(1'b0, 1'b0, ~d1);
		rd(1'b1, q);
		check(q, stat(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0));
		rd(1'b0, q);
		check(q, d1);
		check({7'h0, rxrdy}, 8'h00);
		$display("test sync receive done");
		wr(1'b1, 8'h40);
		wr(1'b1, 8'h5e);
		wr(1'b1, 8'h27);
		repeat (30) @(negedge clk);
		check({rts_n, rx_enable, dtr_n, tx_enable},
			outs(8'h27));
		rd(1'b1, q);
		check(q, stat(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
		u_host.access(1'b1, 1'b1, 1'b0, 8'h00, q);
		repeat (10) @(negedge clk);
		check({rts_n, rx_enable, dtr_n, tx_enable},
			outs(8'h27));
		seed = lfsr(seed);
		send_rx(1'b1, 1'b1, seed[7:0]);
		rd(1'b1, q);
		check(q, stat(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1));
		n = hunt_cnt;
		wr(1'b1, 8'hb7);
		rd(1'b1, q);
		check(q, stat(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
		check(8'(hunt_cnt - n), 8'h00);
		rd(1'b0, q);
		check(q, seed[7:0]);
		$display("test async errors done");
		cts_n = 1'b0;
		repeat (40) @(negedge clk);
		mon_q.delete();
		seed = lfsr(seed);
		s1 = seed[7:0];
		s2 = seed[15:8];
		wr(1'b0, s1);
		// second byte only once the holding register has emptied
		for (n = 0; n < 200; n++) begin
			rd(1'b1, q);
			if (q[0] === 1'b1)
				break;
		end
		// a poll that runs out counts as a mismatch here
		check({7'h0, q[0]}, 8'h01);
		wr(1'b0, s2);
		for (n = 0; n < 4000 && mon_q.size() < 2; n++)
			@(negedge clk);
		// a hang counts as a mismatch and runs on to the verdict
		if (mon_q.size() < 2) begin
			fails++;
		end else begin
			check(mon_q[0][7:0], s1);
			check({7'h0, mon_q[0][8]}, {7'h0, ~^s1});
			check(mon_q[1][7:0], s2);
			check({7'h0, mon_q[1][8]}, {7'h0, ~^s2});
		end
		repeat (200) @(negedge clk);
		check({6'h0, txempty, txrdy}, 8'h03);
		$display("test transmit done");
		report_and_stop();
	end
endmodule : test_usart_host_register_port
